//--- logic/reset_power_supervisor.sv
/*
 Reset merging, watchdog, regulator and comparator control registers.
 Assumes sys_rst is the power-on detector, inputs are synchronous to
 core_clk and the analog comparator and battery detector are outside.
*/
`timescale 1ns/10ps
`default_nettype none
module reset_power_supervisor #(
	parameter int WARMUP_CYCLES = rps_pkg::WARMUP_CYCLES,
	parameter int RST_HOLD_CYCLES = rps_pkg::RST_HOLD_CYCLES
) (
	// Clock and power-on reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Register bus
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// Flash read port for the config word
	output logic [14:0] flash_addr,
	output logic flash_rd,
	input wire logic [7:0] flash_rdata,
	input wire logic flash_valid,
	// Reset sources and operating mode
	input wire logic reset_pin_n,
	input wire logic slow_rc_clock,
	input wire logic battery_low,
	input wire logic comparator_in,
	input wire logic cpu_idle,
	input wire logic cpu_stop,
	// Controls
	output logic chip_rst,
	output logic regulator_enable,
	output logic [2:0] vdd_code,
	output logic [3:0] comparator_divider_select,
	output logic supply_noise_filter,
	output logic flash_app_write_permit,
	output logic [4:0] frc_trim
);
	// ****************
	// Elaboration checks
	// ****************
	if (WARMUP_CYCLES < 1 || WARMUP_CYCLES > 2 ** rps_pkg::CNT_W) begin : g_chk_warm
		$error("WARMUP_CYCLES out of range");
	end
	if (RST_HOLD_CYCLES < 1 || RST_HOLD_CYCLES > 2 ** rps_pkg::CNT_W) begin : g_chk_hold
		$error("RST_HOLD_CYCLES out of range");
	end
	if (rps_pkg::PIN_LOW_SAMPLES < 1 || rps_pkg::PIN_LOW_SAMPLES > 3) begin : g_chk_pin
		$error("PIN_LOW_SAMPLES out of range");
	end

	localparam logic [rps_pkg::CNT_W-1:0] WARM_LOAD = rps_pkg::CNT_W'(WARMUP_CYCLES - 1);
	localparam logic [rps_pkg::CNT_W-1:0] HOLD_LOAD = rps_pkg::CNT_W'(RST_HOLD_CYCLES - 1);
	localparam logic [1:0] PIN_SAMPLES = 2'(rps_pkg::PIN_LOW_SAMPLES);

	typedef struct packed {
		rps_pkg::sup_state_t st;
		logic [rps_pkg::CNT_W-1:0] cnt;
		logic chip_rst;
		logic load_start;
		logic rc_prev;
		logic [1:0] pin_low;
		logic [15:0] wdt;
		logic [7:0] option;
		logic [7:0] regulator_voltage_control;
		logic [7:0] bgsel;
		logic [7:0] aux;
		logic [7:0] cfg_low;
		logic permit;
		logic [2:0] vdd_code;
		logic [7:0] rdata;
	} sup_reg_t;

	sup_reg_t s_r, s_nxt;
	cfg_load_if cfg ();

	config_loader u_loader (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.cfg(cfg),
		.flash_addr(flash_addr),
		.flash_rd(flash_rd),
		.flash_rdata(flash_rdata),
		.flash_valid(flash_valid)
	);

	// ****************
	// Next state
	// ****************
	logic rc_rise;
	logic pin_req;
	logic first_low_voltage_reset_req;
	logic second_low_voltage_reset_req;
	logic cmp_result;
	logic wr_hit;
	logic sw_reset;
	logic wdt_run;
	logic [15:0] wdt_top;
	logic wdt_ovf;
	logic level_req;

	// ****************
	// Functions
	// ****************
	// Idle and stop run on the low-power code, other modes on the run code
	function automatic logic [2:0] pick_code(input logic [7:0] regulator_voltage_control, input logic low_power);
		if (low_power) begin
			return regulator_voltage_control[rps_pkg::REGULATOR_VOLTAGE_CONTROL_LOW_LSB +: 3];
		end
		return regulator_voltage_control[rps_pkg::REGULATOR_VOLTAGE_CONTROL_RUN_LSB +: 3];
	endfunction

	always_comb begin
		s_nxt = s_r;
		s_nxt.load_start = 1'b0;
		rc_rise = slow_rc_clock & ~s_r.rc_prev;
		s_nxt.rc_prev = slow_rc_clock;
		// Slow RC sampling of the pin; one low sample is not a request
		if (rc_rise) begin // see RULE4
			if (!reset_pin_n) begin
				if (s_r.pin_low < PIN_SAMPLES) begin
					s_nxt.pin_low = s_r.pin_low + 2'h1;
				end
			end else begin
				s_nxt.pin_low = 2'h0;
			end
		end
		pin_req = (s_r.pin_low >= PIN_SAMPLES) & ~reset_pin_n & cfg.high[rps_pkg::CFGH_PIN_EN_BIT]; // see RULE5
		first_low_voltage_reset_req = battery_low & cfg.high[rps_pkg::CFGH_FIRST_LOW_VOLTAGE_RESET_EN_BIT]; // see RULE11
		// Disabled comparator reads as low battery
		cmp_result = comparator_in & (s_r.bgsel[3:0] != rps_pkg::CMP_OFF); // see RULE15
		second_low_voltage_reset_req = s_r.bgsel[rps_pkg::BG_SECOND_LOW_VOLTAGE_RESET_EN_BIT] & ~cmp_result; // see RULE13
		level_req = pin_req | first_low_voltage_reset_req;
		wr_hit = sfr_wr & (s_r.st == rps_pkg::ST_RUN);
		sw_reset = wr_hit & (sfr_addr == rps_pkg::ADDR_SOFTWARE_COMMAND) & (sfr_wdata == rps_pkg::SOFTWARE_COMMAND_RESET); // see RULE6
		wdt_run = ~cpu_idle & ~cpu_stop; // see RULE7
		wdt_top = s_r.option[rps_pkg::OPT_WDT_PSC_BIT] ? rps_pkg::WDT_TOP_SHORT : rps_pkg::WDT_TOP_LONG; // see RULE8
		// Overflow without its enable just wraps the counter
		wdt_ovf = wdt_run & (s_r.wdt == wdt_top);

		// Register file and watchdog in normal operation
		if (wr_hit) begin
			case (sfr_addr)
				rps_pkg::ADDR_OPTION: begin
					s_nxt.option = sfr_wdata;
				end
				rps_pkg::ADDR_REGULATOR_VOLTAGE_CONTROL: begin
					s_nxt.regulator_voltage_control = sfr_wdata & rps_pkg::REGULATOR_VOLTAGE_CONTROL_MASK;
				end
				rps_pkg::ADDR_BGSEL: begin
					s_nxt.bgsel = sfr_wdata;
				end
				rps_pkg::ADDR_AUX: begin
					s_nxt.aux = sfr_wdata & rps_pkg::AUX_MASK;
				end
				rps_pkg::ADDR_CFGLOW: begin
					s_nxt.cfg_low = sfr_wdata & rps_pkg::CFGL_MASK; // see RULE23
				end
				rps_pkg::ADDR_SOFTWARE_COMMAND: begin
					s_nxt.permit = (sfr_wdata == rps_pkg::SOFTWARE_COMMAND_PERMIT); // see RULE22
				end
				default: begin
					// Result register and unmapped writes are dropped
				end
			endcase
		end
		// Clear beats overflow at the counter, both leaving it at zero; an enabled overflow still resets the chip
		if (wr_hit && sfr_addr == rps_pkg::ADDR_AUX && sfr_wdata[rps_pkg::AUX_WDCLR_BIT]) begin
			s_nxt.wdt = 16'h0000; // see RULE10
		end else if (wdt_ovf) begin
			s_nxt.wdt = 16'h0000;
		end else if (wdt_run) begin
			s_nxt.wdt = s_r.wdt + 16'h0001; // see RULE7
		end
		// Read data is registered, so the bus sees it one cycle later
		if (sfr_rd) begin
			case (sfr_addr)
				rps_pkg::ADDR_OPTION: begin
					s_nxt.rdata = s_r.option;
				end
				rps_pkg::ADDR_REGULATOR_VOLTAGE_CONTROL: begin
					s_nxt.rdata = s_r.regulator_voltage_control;
				end
				rps_pkg::ADDR_BGSEL: begin
					s_nxt.rdata = s_r.bgsel;
				end
				rps_pkg::ADDR_BGRES: begin
					s_nxt.rdata = {cmp_result, 7'h00}; // see RULE16
				end
				rps_pkg::ADDR_AUX: begin
					s_nxt.rdata = s_r.aux;
				end
				rps_pkg::ADDR_CFGLOW: begin
					s_nxt.rdata = s_r.cfg_low;
				end
				rps_pkg::ADDR_SOFTWARE_COMMAND: begin
					s_nxt.rdata = {7'h00, s_r.permit}; // see RULE22
				end
				default: begin
					s_nxt.rdata = 8'h00;
				end
			endcase
		end
		s_nxt.vdd_code = pick_code(s_nxt.regulator_voltage_control, cpu_idle | cpu_stop); // see RULE18, RULE19

		// Reset sequencing
		case (s_r.st)
			rps_pkg::ST_WARMUP: begin
				if (s_r.cnt == '0) begin // see RULE1
					s_nxt.st = rps_pkg::ST_LOAD;
					s_nxt.load_start = 1'b1;
				end else begin
					s_nxt.cnt = s_r.cnt - 1'b1;
				end
			end
			rps_pkg::ST_LOAD: begin
				if (cfg.done) begin // see RULE1
					s_nxt.st = rps_pkg::ST_RUN;
					s_nxt.chip_rst = 1'b0;
					s_nxt.cfg_low = cfg.low & rps_pkg::CFGL_MASK; // see RULE23
				end
			end
			rps_pkg::ST_RUN: begin
				// Any source asserts at once; no reload of the config word
				if (level_req || second_low_voltage_reset_req || sw_reset || (wdt_ovf && cfg.high[rps_pkg::CFGH_WDT_EN_BIT])) begin // see RULE24, RULE9, RULE2
					s_nxt.st = rps_pkg::ST_HOLD;
					s_nxt.chip_rst = 1'b1;
					s_nxt.cnt = HOLD_LOAD;
				end
			end
			rps_pkg::ST_HOLD: begin
				// Level sources stretch the hold; release is clocked
				if (level_req) begin // see RULE24
					s_nxt.cnt = HOLD_LOAD;
				end else if (s_r.cnt == '0) begin
					s_nxt.st = rps_pkg::ST_RUN;
					s_nxt.chip_rst = 1'b0;
				end else begin
					s_nxt.cnt = s_r.cnt - 1'b1;
				end
			end
			default: begin
				s_nxt.st = rps_pkg::ST_HOLD;
				s_nxt.chip_rst = 1'b1;
				s_nxt.cnt = HOLD_LOAD;
			end
		endcase

		// Registers other than F7h sit at defaults for as long as the chip is in reset; F7h keeps its value
		if (s_nxt.st != rps_pkg::ST_RUN) begin // see RULE3
			s_nxt.option = rps_pkg::OPTION_RST;
			s_nxt.regulator_voltage_control = rps_pkg::REGULATOR_VOLTAGE_CONTROL_RST; // see RULE17
			s_nxt.bgsel = rps_pkg::BGSEL_RST;
			s_nxt.aux = rps_pkg::AUX_RST;
			s_nxt.permit = 1'b0;
			s_nxt.wdt = 16'h0000; // see RULE10
			s_nxt.rdata = 8'h00;
			s_nxt.vdd_code = rps_pkg::REGULATOR_VOLTAGE_CONTROL_RST[rps_pkg::REGULATOR_VOLTAGE_CONTROL_RUN_LSB +: 3];
		end
	end

	// ****************
	// State register
	// ****************
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			// Warm-up starts with the chip held in reset
			s_r <= '{st: rps_pkg::ST_WARMUP,
				cnt: WARM_LOAD,
				chip_rst: 1'b1,
				load_start: 1'b0,
				rc_prev: 1'b0,
				pin_low: 2'h0,
				wdt: 16'h0000,
				option: rps_pkg::OPTION_RST,
				regulator_voltage_control: rps_pkg::REGULATOR_VOLTAGE_CONTROL_RST,
				bgsel: rps_pkg::BGSEL_RST,
				aux: rps_pkg::AUX_RST,
				cfg_low: 8'h00,
				permit: 1'b0,
				vdd_code: rps_pkg::REGULATOR_VOLTAGE_CONTROL_RST[rps_pkg::REGULATOR_VOLTAGE_CONTROL_RUN_LSB +: 3],
				rdata: 8'h00
			};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************
	// Outputs
	// ****************
	assign cfg.start = s_r.load_start;
	assign chip_rst = s_r.chip_rst;
	assign sfr_rdata = s_r.rdata;
	assign regulator_enable = s_r.regulator_voltage_control[rps_pkg::REGULATOR_VOLTAGE_CONTROL_REG_EN_BIT]; // see RULE17
	assign vdd_code = s_r.vdd_code;
	assign comparator_divider_select = s_r.bgsel[rps_pkg::BG_SEL_LSB +: 4]; // see RULE15
	assign supply_noise_filter = s_r.option[rps_pkg::OPT_NOISE_BIT]; // see RULE21
	assign flash_app_write_permit = s_r.permit;
	assign frc_trim = s_r.cfg_low[4:0];
endmodule
`default_nettype wire

//--- shared/rps_pkg.sv
/*
 Constants, layouts and state types of the reset and power supervisor.
 Assumes an 8051-style byte register bus and a byte-wide flash read port.
*/
// Behaviour
// RULE1: After power-on, hold reset 20 ms, then load config word from last flash bytes.
// RULE2: Non power-on resets keep the loaded config word; no reload.
// RULE3: Every reset source returns all registers to defaults. Code keeps the written F7h value through non power-on resets.
// RULE4: Outside party holds reset pin low at least 2 slow RC cycles.
// RULE5: Reset pin acts only when config high bit 6 is set.
// RULE6: Writing 56h to the command register at 97h resets the chip.
// RULE7: Watchdog counts in fast and slow modes, stops in idle and stop.
// RULE8: Watchdog overflows after 65536 counts, or 32768 with prescale bit set.
// RULE9: Watchdog overflow resets only when config high bit 4 is set.
// RULE10: Any reset or writing 1 to bit 3 at F8h clears the watchdog.
// RULE11: With config bit 1 set, battery detector low input resets the chip.
// RULE12: Firmware keeps the first low-voltage reset enabled always.
// RULE13: Bit 7 at C2h set and comparator result 0 resets the chip.
// RULE14: Firmware sets divider select and waits for bandgap before enabling.
// RULE15: Divider select 0000 disables comparator; other codes pick trip levels.
// RULE16: Bit 7 at C3h reads comparator result, 1 when battery divider higher.
// RULE17: Bit 6 at A7h drives regulator enable; resets to 1.
// RULE18: Run voltage code, A7h bits 5..3, applies in fast and slow modes.
// RULE19: Low-power code, A7h bits 2..0, applies in idle and stop.
// RULE20: Firmware uses regulator off, or on with code 7, on fast clocks.
// RULE21: Bit 4 at 94h drives the supply noise filter output.
// RULE22: Writing 65h sets flash write permit, other values clear; reads bit 0.
// RULE23: After power-on the config low byte is copied to F7h, then writable.
// RULE24: All reset sources merge into one chip reset with synchronous release.
package rps_pkg;
	// ****************
	// Timing
	// ****************
	localparam int CLK_HZ = 25_000_000;
	localparam int WARMUP_MS = 20;
	localparam int WARMUP_CYCLES = CLK_HZ / 1000 * WARMUP_MS;
	localparam int RST_HOLD_CYCLES = 4;
	localparam int PIN_LOW_SAMPLES = 2;
	localparam int CNT_W = 20;
	localparam logic [15:0] WDT_TOP_LONG = 16'hFFFF;
	localparam logic [15:0] WDT_TOP_SHORT = 16'h7FFF;

	// ****************
	// Register map
	// ****************
	localparam logic [7:0] ADDR_OPTION = 8'h94;
	localparam logic [7:0] ADDR_SOFTWARE_COMMAND = 8'h97;
	localparam logic [7:0] ADDR_REGULATOR_VOLTAGE_CONTROL = 8'hA7;
	localparam logic [7:0] ADDR_BGSEL = 8'hC2;
	localparam logic [7:0] ADDR_BGRES = 8'hC3;
	localparam logic [7:0] ADDR_CFGLOW = 8'hF7;
	localparam logic [7:0] ADDR_AUX = 8'hF8;
	localparam logic [14:0] FLASH_CFG_LOW = 15'h7FFE;
	localparam logic [14:0] FLASH_CFG_HIGH = 15'h7FFF;

	// ****************
	// Fields and resets
	// ****************
	localparam int OPT_NOISE_BIT = 4;
	localparam int OPT_WDT_PSC_BIT = 2;
	localparam int REGULATOR_VOLTAGE_CONTROL_REG_EN_BIT = 6;
	localparam int REGULATOR_VOLTAGE_CONTROL_RUN_LSB = 3;
	localparam int REGULATOR_VOLTAGE_CONTROL_LOW_LSB = 0;
	localparam int BG_SECOND_LOW_VOLTAGE_RESET_EN_BIT = 7;
	localparam int BG_SEL_LSB = 0;
	localparam int RES_CMP_BIT = 7;
	localparam int AUX_WDCLR_BIT = 3;
	localparam int CFGH_PIN_EN_BIT = 6;
	localparam int CFGH_WDT_EN_BIT = 4;
	localparam int CFGH_FIRST_LOW_VOLTAGE_RESET_EN_BIT = 1;
	localparam int SOFTWARE_COMMAND_PERMIT_BIT = 0;
	localparam logic [7:0] OPTION_RST = 8'hC1;
	localparam logic [7:0] REGULATOR_VOLTAGE_CONTROL_RST = 8'h7F;
	localparam logic [7:0] REGULATOR_VOLTAGE_CONTROL_MASK = 8'h7F;
	localparam logic [7:0] BGSEL_RST = 8'h00;
	localparam logic [7:0] AUX_RST = 8'h00;
	localparam logic [7:0] AUX_MASK = 8'h17;
	localparam logic [7:0] CFGL_MASK = 8'h1F;
	localparam logic [3:0] CMP_OFF = 4'h0;
	localparam logic [7:0] SOFTWARE_COMMAND_RESET = 8'h56;
	localparam logic [7:0] SOFTWARE_COMMAND_PERMIT = 8'h65;

	typedef enum logic [1:0] {ST_WARMUP, ST_LOAD, ST_RUN, ST_HOLD} sup_state_t;
	typedef enum logic [1:0] {LD_IDLE, LD_LOW, LD_HIGH} load_state_t;
endpackage

//--- shared/cfg_load_if.sv
/*
 Handshake between the supervisor and its config word loader.
 Assumes both ends run on core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
interface cfg_load_if;
	logic start;
	logic done;
	logic [7:0] high;
	logic [7:0] low;
	modport sup (output start, input done, input high, input low);
	modport ldr (input start, output done, output high, output low);
endinterface
`default_nettype wire

//--- logic/config_loader.sv
/*
 Fetches the two config bytes from the top of flash on request.
 Assumes the flash answers a held read with one flash_valid pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module config_loader (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Supervisor side
	cfg_load_if.ldr cfg,
	// Flash read port
	output logic [14:0] flash_addr,
	output logic flash_rd,
	input wire logic [7:0] flash_rdata,
	input wire logic flash_valid
);
	typedef struct packed {
		rps_pkg::load_state_t st;
		logic [14:0] addr;
		logic rd;
		logic done;
		logic [7:0] high;
		logic [7:0] low;
	} ldr_state_t;

	ldr_state_t s_r, s_nxt;

	// Kept across chip resets: only power-on clears it
	always_comb begin // see RULE2
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		case (s_r.st)
			rps_pkg::LD_IDLE: begin
				if (cfg.start) begin
					s_nxt.addr = rps_pkg::FLASH_CFG_LOW;
					s_nxt.rd = 1'b1;
					s_nxt.st = rps_pkg::LD_LOW;
				end
			end
			rps_pkg::LD_LOW: begin
				if (flash_valid) begin
					s_nxt.low = flash_rdata;
					s_nxt.addr = rps_pkg::FLASH_CFG_HIGH;
					s_nxt.st = rps_pkg::LD_HIGH;
				end
			end
			rps_pkg::LD_HIGH: begin
				if (flash_valid) begin
					s_nxt.high = flash_rdata;
					s_nxt.rd = 1'b0;
					s_nxt.done = 1'b1;
					s_nxt.st = rps_pkg::LD_IDLE;
				end
			end
			default: begin
				s_nxt.st = rps_pkg::LD_IDLE;
				s_nxt.rd = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign cfg.done = s_r.done;
	assign cfg.high = s_r.high;
	assign cfg.low = s_r.low;
	assign flash_addr = s_r.addr;
	assign flash_rd = s_r.rd;
endmodule
`default_nettype wire

//--- testbench/rps_assertions.sv
/*
 Port checker for the reset and power supervisor.
 Assumes it is bound onto reset_power_supervisor.
*/
`timescale 1ns/10ps
`default_nettype none
module rps_assertions #(
	parameter int WARMUP_CYCLES = 20
) (
	// Clock, reset and bus
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	// Flash, analog side and operating mode
	input wire logic [14:0] flash_addr,
	input wire logic flash_rd,
	input wire logic flash_valid,
	input wire logic comparator_in,
	input wire logic cpu_idle,
	input wire logic cpu_stop,
	// Controls
	input wire logic chip_rst,
	input wire logic regulator_enable,
	input wire logic [2:0] vdd_code,
	input wire logic [3:0] comparator_divider_select,
	input wire logic supply_noise_filter,
	input wire logic flash_app_write_permit
);
	// ****************
	// Warm-up counter
	// ****************
	logic [19:0] warm_r;
	logic [19:0] warm_nxt;
	wire logic run_wr = sfr_wr && !chip_rst;
	always_comb warm_nxt = (warm_r < 20'(WARMUP_CYCLES)) ? warm_r + 20'h1 : warm_r;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			warm_r <= 20'h0;
		else
			warm_r <= warm_nxt;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	a_warmup_hold: assert property (warm_r < 20'(WARMUP_CYCLES - 1) |-> chip_rst && !flash_rd)
		else $error("reset left during warm-up");
	a_load_low_first: assert property ($rose(flash_rd) |-> flash_addr == 15'h7FFE)
		else $error("config load did not start at low byte");
	a_load_high_next: assert property (flash_rd && flash_valid && flash_addr == 15'h7FFE
		|=> flash_rd && flash_addr == 15'h7FFF)
		else $error("config high byte not fetched next");
	a_load_release: assert property (flash_rd && flash_valid && flash_addr == 15'h7FFF
		|=> !flash_rd ##1 !chip_rst)
		else $error("chip reset not released after load");
	a_reset_defaults: assert property (chip_rst [*3] |-> regulator_enable && vdd_code == 3'h7
		&& comparator_divider_select == 4'h0 && !supply_noise_filter && !flash_app_write_permit)
		else $error("controls not at defaults in reset");
	a_software_reset_command_fires: assert property (run_wr && sfr_addr == 8'h97 && sfr_wdata == 8'h56 |=> chip_rst)
		else $error("software reset command ignored");
	a_permit_flag: assert property (run_wr && sfr_addr == 8'h97
		|=> flash_app_write_permit == ($past(sfr_wdata) == 8'h65))
		else $error("write permit flag wrong");
	a_noise_follow: assert property (run_wr && sfr_addr == 8'h94 ##1 !(sfr_wr && sfr_addr == 8'h94) && !chip_rst
		|=> chip_rst || supply_noise_filter == $past(sfr_wdata[4], 2))
		else $error("noise filter output wrong");
	a_regen_follow: assert property (run_wr && sfr_addr == 8'hA7 ##1 !(sfr_wr && sfr_addr == 8'hA7) && !chip_rst
		|=> chip_rst || regulator_enable == $past(sfr_wdata[6], 2))
		else $error("regulator enable output wrong");
	a_vdd_select: assert property (run_wr && sfr_addr == 8'hA7 ##1 !(sfr_wr && sfr_addr == 8'hA7) && !chip_rst
		|=> chip_rst || vdd_code == (($past(cpu_idle) || $past(cpu_stop)) ?
		$past(sfr_wdata[2:0], 2) : $past(sfr_wdata[5:3], 2)))
		else $error("voltage code selection wrong");
	a_second_low_voltage_reset_fires: assert property (run_wr && sfr_addr == 8'hC2 && sfr_wdata[7] && !comparator_in
		##1 !comparator_in |-> ##[0:2] chip_rst)
		else $error("comparator low reset missing");
endmodule
bind reset_power_supervisor rps_assertions #(.WARMUP_CYCLES(WARMUP_CYCLES)) chk_i (.core_clk, .sys_rst,
	.sfr_addr, .sfr_wr, .sfr_wdata, .flash_addr, .flash_rd, .flash_valid, .comparator_in, .cpu_idle,
	.cpu_stop, .chip_rst, .regulator_enable, .vdd_code, .comparator_divider_select, .supply_noise_filter,
	.flash_app_write_permit);
`default_nettype wire

//--- testbench/tb_top.sv
/*
 Self-checking bench for the reset and power supervisor.
 Assumes the bench stands in for flash, pins and the analog side.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	// ****************
	// Stimulus
	// ****************
	logic core_clk, sys_rst, sfr_wr, sfr_rd, reset_pin_n, battery_low, comparator_in, cpu_idle, cpu_stop;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, cfg_hi, cfg_lo;
	logic flash_valid = 1'b0;
	logic slow_rc_clock = 1'b0;
	logic [7:0] flash_rdata = 8'h00;
	logic [2:0] rc_div = 3'h0;
	logic [14:0] flash_addr;
	logic flash_rd, chip_rst, regulator_enable, supply_noise_filter, flash_app_write_permit;
	logic [2:0] vdd_code;
	logic [3:0] comparator_divider_select;
	logic [4:0] frc_trim;
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;
	reset_power_supervisor #(.WARMUP_CYCLES(20)) dut (.core_clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd,
		.sfr_wdata, .sfr_rdata, .flash_addr, .flash_rd, .flash_rdata, .flash_valid, .reset_pin_n,
		.slow_rc_clock, .battery_low, .comparator_in, .cpu_idle, .cpu_stop, .chip_rst, .regulator_enable,
		.vdd_code, .comparator_divider_select, .supply_noise_filter, .flash_app_write_permit, .frc_trim);
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// Flash stand-in: data toggles while nothing is asked
	always @(negedge core_clk) begin
		flash_valid <= flash_rd && !flash_valid && !sys_rst;
		flash_rdata <= !flash_rd ? ~flash_rdata : (flash_addr == 15'h7FFF) ? cfg_hi : cfg_lo;
		rc_div <= rc_div + 3'h1;
		slow_rc_clock <= rc_div[2];
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 80000) begin
			fails++;
			test_done();
		end
	end
	task automatic test_done();
		if (fails == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge core_clk);
		sfr_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge core_clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge core_clk);
		sfr_rd = 1'b0;
		chk(sfr_rdata, exp);
	endtask
	task automatic wait_rst(input logic v, input int n);
		int i;
		i = 0;
		while (chip_rst !== v && i < n) begin
			@(negedge core_clk);
			i++;
		end
		chk(8'(chip_rst), 8'(v));
	endtask
	task automatic power_on(input logic [7:0] hi, input logic [7:0] lo);
		cfg_hi = hi;
		cfg_lo = lo;
		sys_rst = 1'b1;
		repeat (4) @(negedge core_clk);
		sys_rst = 1'b0;
		repeat (10) @(negedge core_clk);
		chk(8'(chip_rst), 8'h01);
		wait_rst(1'b0, 60);
		rd(8'hF7, lo & 8'h1F);
		chk(8'(frc_trim), lo & 8'h1F);
	endtask
	task automatic defaults(input logic [7:0] trim);
		rd(8'h94, 8'hC1);
		rd(8'hA7, 8'h7F);
		rd(8'hC2, 8'h00);
		rd(8'hF8, 8'h00);
		rd(8'h97, 8'h00);
		rd(8'hF7, trim);
		chk(8'(vdd_code), 8'h07);
	endtask
	initial begin
		{sys_rst, sfr_wr, sfr_rd, battery_low, cpu_idle, cpu_stop} = 6'h20;
		{reset_pin_n, comparator_in, sfr_addr, sfr_wdata} = 18'h30000;
		power_on(8'h52, 8'h15);
		defaults(8'h15);
		rd(8'h80, 8'h00);
		wr(8'hA7, 8'h25);
		rd(8'hA7, 8'h25);
		chk(8'(regulator_enable), 8'h00);
		chk(8'(vdd_code), 8'h04);
		cpu_idle = 1'b1;
		repeat (2) @(negedge core_clk);
		chk(8'(vdd_code), 8'h05);
		{cpu_idle, cpu_stop} = 2'h1;
		repeat (2) @(negedge core_clk);
		chk(8'(vdd_code), 8'h05);
		cpu_stop = 1'b0;
		wr(8'hA7, 8'h7F);
		chk(8'(regulator_enable), 8'h01);
		chk(8'(vdd_code), 8'h07);
		wr(8'h94, 8'hD1);
		rd(8'h94, 8'hD1);
		chk(8'(supply_noise_filter), 8'h01);
		for (int i = 0; i < 16; i++) begin
			wr(8'hC2, 8'(i));
			rd(8'hC3, (i == 0) ? 8'h00 : 8'h80);
			chk(8'(comparator_divider_select), 8'(i));
		end
		comparator_in = 1'b0;
		wr(8'hC3, 8'hFF);
		rd(8'hC3, 8'h00);
		comparator_in = 1'b1;
		wr(8'h97, 8'h65);
		rd(8'h97, 8'h01);
		wr(8'h97, 8'h12);
		chk(8'(flash_app_write_permit), 8'h00);
		wr(8'hF7, 8'hEA);
		chk(8'(frc_trim), 8'h0A);
		wr(8'hF8, 8'hFF);
		rd(8'hF8, 8'h17);
		wr(8'h97, 8'h56);
		wait_rst(1'b1, 3);
		wait_rst(1'b0, 10);
		defaults(8'h0A);
		reset_pin_n = 1'b0;
		repeat (20) @(negedge core_clk);
		wait_rst(1'b1, 20);
		reset_pin_n = 1'b1;
		wait_rst(1'b0, 40);
		battery_low = 1'b1;
		wait_rst(1'b1, 5);
		battery_low = 1'b0;
		wait_rst(1'b0, 10);
		comparator_in = 1'b0;
		wr(8'hC2, 8'h01);
		wr(8'hC2, 8'h81);
		wait_rst(1'b1, 5);
		comparator_in = 1'b1;
		wait_rst(1'b0, 10);
		defaults(8'h0A);
		wr(8'h94, 8'hC5);
		wr(8'hF8, 8'h08);
		cpu_idle = 1'b1;
		repeat (1000) @(negedge core_clk);
		{cpu_idle, cpu_stop} = 2'h1;
		repeat (1000) @(negedge core_clk);
		cpu_stop = 1'b0;
		repeat (32700) @(negedge core_clk);
		chk(8'(chip_rst), 8'h00);
		wait_rst(1'b1, 100);
		wait_rst(1'b0, 10);
		rd(8'h94, 8'hC1);
		power_on(8'h00, 8'h0C);
		{reset_pin_n, battery_low} = 2'h1;
		repeat (40) @(negedge core_clk);
		chk(8'(chip_rst), 8'h00);
		{reset_pin_n, battery_low} = 2'h2;
		test_done();
	end
endmodule
`default_nettype wire
